// file: pcpc_pkg.sv
// Package: promotion control packet layout, message coding and link sizes
package pcpc_pkg;
  localparam int          PCPC_ADDR_W         = 48;
  localparam int          PCPC_COST_W         = 8;
  localparam int          PCPC_NSID_W         = 8;
  localparam int          PCPC_RQ_W           = 3;
  localparam int          PCPC_TIME_W         = 3;
  localparam int          PCPC_RESV_W         = 4;
  localparam int          PCPC_SHORT_BYTES    = 2;
  localparam int          PCPC_LONG_BYTES     = 11;
  localparam logic [7:0]  PCPC_NSID_NONE      = 8'hFF;
  localparam logic [3:0]  PCPC_CTYPE_PROMO    = 4'h3;
  localparam logic [3:0]  PCPC_CTYPE_BSI      = 4'h4;
  localparam logic [3:0]  PCPC_RESV_VALUE     = 4'h0;
  // Bit positions inside the first short-form byte
  localparam int          PCPC_POS_NEG        = 7;
  localparam int          PCPC_POS_RESV1      = 6;
  localparam int          PCPC_POS_RQ         = 3;
  localparam int          PCPC_POS_TIME       = 0;
  // Bit positions inside the capability byte
  localparam int          PCPC_POS_DC         = 3;
  localparam int          PCPC_POS_MC         = 2;
  localparam int          PCPC_POS_PRM        = 1;
  localparam int          PCPC_POS_ARQ        = 0;
  localparam int          PCPC_POS_CRESV      = 4;

  typedef enum logic [2:0] {
    PCPC_MSG_REQ_NODE,
    PCPC_MSG_REQ_BASE,
    PCPC_MSG_ACK,
    PCPC_MSG_REJECT,
    PCPC_MSG_DEM_NODE,
    PCPC_MSG_DEM_BASE,
    PCPC_MSG_INVALID
  } pcpc_msg_t;

  // Sort a message by direction, negative flag and new switch identifier
  function automatic pcpc_msg_t pcpc_classify(input logic       dn,
                                              input logic       neg,
                                              input logic [7:0] nsid);
    logic none;
    none = (nsid == PCPC_NSID_NONE);
    case ({dn, neg, none})
      3'b001:  pcpc_classify = PCPC_MSG_REQ_NODE;
      3'b100:  pcpc_classify = PCPC_MSG_REQ_BASE;
      3'b000:  pcpc_classify = PCPC_MSG_ACK;
      3'b111:  pcpc_classify = PCPC_MSG_REJECT;
      3'b010:  pcpc_classify = PCPC_MSG_DEM_NODE;
      3'b110:  pcpc_classify = PCPC_MSG_DEM_BASE;
      default: pcpc_classify = PCPC_MSG_INVALID;
    endcase
  endfunction : pcpc_classify
endpackage : pcpc_pkg

// file: pcpc_link_if.sv
// Interface: byte-serial promotion packet link between node and base MACs
`timescale 1ns/1ps
interface pcpc_link_if;
  // Uplink: node to base
  logic       up_valid;
  logic       up_first;
  logic       up_last;
  logic [7:0] up_byte;
  // Downlink: base to node
  logic       dn_valid;
  logic       dn_first;
  logic       dn_last;
  logic [7:0] dn_byte;

  modport node_end (
    output up_valid, up_first, up_last, up_byte,
    input  dn_valid, dn_first, dn_last, dn_byte
  );
  modport base_end (
    input  up_valid, up_first, up_last, up_byte,
    output dn_valid, dn_first, dn_last, dn_byte
  );
endinterface : pcpc_link_if

// file: pcpc_node_end.sv
// Service node end: builds uplink promotion packets, decodes downlink ones
//
// Summary of operation
// - Node request carries 48-bit requester address
// - Node request carries 8-bit uplink cost
// - Node request carries 8-bit downlink cost
// - Four reserved capability bits sent as zero
// - Direct switch flag reflects capability
// - Multicast flag reflects capability
// - Robustness management flag reflects capability
// - Retransmit buffering flag reflects capability
// - Uplink, positive, identifier FF is node request
// - Positive below FF: accept, base request, ack
// - Downlink negative FF is base reject
// - Uplink negative below FF demotes node
// - Downlink negative below FF demotes node
// - Beacon slot packet only for switches
// - Negative flag set for reject or demote
// - Identifier is the newly assigned switch id
// - Base promotion message restarts keep-alive timer
//
// The byte-serial link framing with first and last flags is this design's own decision.
`timescale 1ns/1ps
module pcpc_node_end
  import pcpc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  pcpc_link_if.node_end               link,
  input  wire logic                   send_req,
  input  wire pcpc_msg_t              send_kind,
  input  wire logic [PCPC_RQ_W-1:0]   send_rq,
  input  wire logic [PCPC_TIME_W-1:0] send_time,
  input  wire logic [7:0]             send_nsid,
  input  wire logic [PCPC_ADDR_W-1:0] send_need_addr,
  input  wire logic [PCPC_COST_W-1:0] send_up_cost,
  input  wire logic [PCPC_COST_W-1:0] send_dn_cost,
  input  wire logic                   cap_direct,
  input  wire logic                   cap_multicast,
  input  wire logic                   cap_robust,
  input  wire logic                   cap_retransmit,
  output logic                        send_busy,
  output logic                        promoted,
  output logic [7:0]                  switch_ident,
  output logic                        keepalive_restart,
  output logic [PCPC_TIME_W-1:0]      keepalive_code,
  output logic                        rx_msg_valid,
  output pcpc_msg_t                   rx_msg_kind,
  output logic                        rx_discard
);
  localparam int BW = PCPC_LONG_BYTES * 8;

  // Transmit state
  logic [BW-1:0] tx_sh_reg, tx_sh_next;
  logic [3:0]    tx_cnt_reg, tx_cnt_next;
  logic          tx_v_reg, tx_v_next, tx_f_reg, tx_f_next, tx_l_reg, tx_l_next;
  logic [7:0]    tx_b_reg, tx_b_next;

  // Packet builder; only the node request takes the long form
  always_comb begin
    logic neg;
    logic [7:0] b0;
    logic [7:0] cap;
    neg = (send_kind == PCPC_MSG_DEM_NODE);
    b0  = '0;
    b0[PCPC_POS_NEG] = neg;
    b0[PCPC_POS_RESV1] = 1'b0;
    b0[PCPC_POS_RQ +: PCPC_RQ_W] = send_rq;
    b0[PCPC_POS_TIME +: PCPC_TIME_W] = send_time;
    cap = '0;
    cap[PCPC_POS_CRESV +: PCPC_RESV_W] = PCPC_RESV_VALUE;
    cap[PCPC_POS_DC]  = cap_direct;
    cap[PCPC_POS_MC]  = cap_multicast;
    cap[PCPC_POS_PRM] = cap_robust;
    cap[PCPC_POS_ARQ] = cap_retransmit;
    tx_sh_next  = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_v_next = 1'b0;
    tx_f_next = 1'b0;
    tx_l_next = 1'b0;
    tx_b_next = tx_b_reg;
    if (tx_cnt_reg != 4'h0) begin
      tx_v_next = 1'b1;
      tx_b_next = tx_sh_reg[BW-1 -: 8];
      tx_l_next = (tx_cnt_reg == 4'h1);
      tx_sh_next = {tx_sh_reg[BW-9:0], 8'h00};
      tx_cnt_next = tx_cnt_reg - 4'h1;
    end else if (send_req) begin
      tx_v_next = 1'b1;
      tx_f_next = 1'b1;
      tx_b_next = b0;
      if (send_kind == PCPC_MSG_REQ_NODE) begin
        // Identifier FF marks a node-originated request; bytes leave
        // from the top, so the spare low byte only pads the register
        tx_sh_next = {PCPC_NSID_NONE, send_need_addr,
                      send_up_cost, send_dn_cost, cap, 8'h00};
        tx_cnt_next = 4'(PCPC_LONG_BYTES - 1);
      end else begin
        tx_sh_next = {send_nsid, {(BW-8){1'b0}}};
        tx_cnt_next = 4'(PCPC_SHORT_BYTES - 1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_reg  <= '0;
      tx_cnt_reg <= 4'h0;
      tx_v_reg   <= 1'b0;
      tx_f_reg   <= 1'b0;
      tx_l_reg   <= 1'b0;
      tx_b_reg   <= 8'h00;
    end else begin
      tx_sh_reg  <= tx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_v_reg   <= tx_v_next;
      tx_f_reg   <= tx_f_next;
      tx_l_reg   <= tx_l_next;
      tx_b_reg   <= tx_b_next;
    end
  end

  assign link.up_valid = tx_v_reg;
  assign link.up_first = tx_f_reg;
  assign link.up_last  = tx_l_reg;
  assign link.up_byte  = tx_b_reg;

  // Busy is registered from the next byte count and valid; a request is ignored only while the count is nonzero
  logic busy_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busy_reg <= 1'b0;
    else        busy_reg <= (tx_cnt_next != 4'h0) || tx_v_next;
  end
  assign send_busy = busy_reg;

  // Receive state: downlink short packets only
  logic [7:0]      rx_b0_reg, rx_b0_next;
  logic            rx_wait_reg, rx_wait_next;
  logic            prom_reg, prom_next;
  logic [7:0]      sid_reg, sid_next;
  logic            ka_reg, ka_next;
  logic [2:0]      kac_reg, kac_next;
  logic            mv_reg, mv_next, disc_reg, disc_next;
  pcpc_msg_t       mk_reg, mk_next;

  // Decode downlink messages and update promotion state
  always_comb begin
    pcpc_msg_t k;
    k = PCPC_MSG_INVALID;
    rx_b0_next = rx_b0_reg;
    rx_wait_next = rx_wait_reg;
    prom_next = prom_reg;
    sid_next = sid_reg;
    ka_next = 1'b0;
    kac_next = kac_reg;
    mv_next = 1'b0;
    disc_next = 1'b0;
    mk_next = mk_reg;
    // A demotion the node sends with an identifier below FF is taken as its own demotion; a
    // downlink decode in the same cycle below still wins
    if (send_req && tx_cnt_reg == 4'h0 &&
        send_kind == PCPC_MSG_DEM_NODE &&
        send_nsid != PCPC_NSID_NONE) begin
      prom_next = 1'b0;
    end
    if (link.dn_valid && link.dn_first) begin
      rx_b0_next = link.dn_byte;
      rx_wait_next = !link.dn_last;
    end else if (link.dn_valid && rx_wait_reg) begin
      rx_wait_next = 1'b0;
      k = pcpc_classify(1'b1, rx_b0_reg[PCPC_POS_NEG], link.dn_byte);
      case (k)
        PCPC_MSG_REQ_BASE: begin
          prom_next = 1'b1;
          sid_next = link.dn_byte;
          ka_next = 1'b1;
          kac_next = rx_b0_reg[PCPC_POS_TIME +: PCPC_TIME_W];
        end
        PCPC_MSG_REJECT:   prom_next = 1'b0;
        PCPC_MSG_DEM_BASE: prom_next = 1'b0;
        default: ;
      endcase
      if (k == PCPC_MSG_INVALID) begin
        disc_next = 1'b1;
      end else begin
        mv_next = 1'b1;
        mk_next = k;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_b0_reg <= 8'h00;
      rx_wait_reg <= 1'b0;
      prom_reg <= 1'b0;
      sid_reg <= PCPC_NSID_NONE;
      ka_reg <= 1'b0;
      kac_reg <= '0;
      mv_reg <= 1'b0;
      disc_reg <= 1'b0;
      mk_reg <= PCPC_MSG_INVALID;
    end else begin
      rx_b0_reg <= rx_b0_next;
      rx_wait_reg <= rx_wait_next;
      prom_reg <= prom_next;
      sid_reg <= sid_next;
      ka_reg <= ka_next;
      kac_reg <= kac_next;
      mv_reg <= mv_next;
      disc_reg <= disc_next;
      mk_reg <= mk_next;
    end
  end

  // Status outputs come straight from their registers
  assign promoted          = prom_reg;
  assign switch_ident      = sid_reg;
  assign keepalive_restart = ka_reg;
  assign keepalive_code    = kac_reg;
  assign rx_msg_valid      = mv_reg;
  assign rx_msg_kind       = mk_reg;
  assign rx_discard        = disc_reg;
endmodule : pcpc_node_end

// file: pcpc_base_end.sv
// Base node end: decodes uplink promotion packets, builds downlink replies
`timescale 1ns/1ps
module pcpc_base_end
  import pcpc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  pcpc_link_if.base_end               link,
  input  wire logic                   send_req,
  input  wire pcpc_msg_t              send_kind,
  input  wire logic [PCPC_RQ_W-1:0]   send_rq,
  input  wire logic [PCPC_TIME_W-1:0] send_time,
  input  wire logic [7:0]             send_nsid,
  output logic                        node_promoted,
  output logic [7:0]                  node_ident,
  output logic                        rx_msg_valid,
  output pcpc_msg_t                   rx_msg_kind,
  output logic [PCPC_ADDR_W-1:0]      rx_need_addr,
  output logic [PCPC_COST_W-1:0]      rx_up_cost,
  output logic [PCPC_COST_W-1:0]      rx_dn_cost,
  output logic [3:0]                  rx_caps,
  output logic                        rx_discard
);
  localparam int BW = PCPC_LONG_BYTES * 8;

  // Transmit: downlink always short form
  logic [7:0] tx_b_reg, tx_b_next, tx_hold_reg, tx_hold_next;
  logic       tx_v_reg, tx_v_next, tx_f_reg, tx_f_next, tx_l_reg, tx_l_next;
  logic       tx_pend_reg, tx_pend_next;
  logic       prom_reg, prom_next;
  logic [7:0] sid_reg, sid_next;

  // Byte stream collected on the uplink
  logic [BW-1:0] rx_sh_reg, rx_sh_next;
  logic [3:0]    rx_cnt_reg, rx_cnt_next;
  logic          mv_reg, mv_next, disc_reg, disc_next;
  pcpc_msg_t     mk_reg, mk_next;
  logic [PCPC_ADDR_W-1:0] na_reg, na_next;
  logic [7:0]    uc_reg, uc_next, dc_reg, dc_next;
  logic [3:0]    cap_reg, cap_next;

  always_comb begin
    logic [BW-1:0] full;
    logic [7:0] b0;
    pcpc_msg_t k;
    full = {rx_sh_reg[BW-9:0], link.up_byte};
    b0 = '0;
    k = PCPC_MSG_INVALID;
    tx_b_next = tx_b_reg;
    tx_hold_next = tx_hold_reg;
    tx_v_next = 1'b0;
    tx_f_next = 1'b0;
    tx_l_next = 1'b0;
    tx_pend_next = 1'b0;
    prom_next = prom_reg;
    sid_next = sid_reg;
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    mv_next = 1'b0;
    disc_next = 1'b0;
    mk_next = mk_reg;
    na_next = na_reg;
    uc_next = uc_reg;
    dc_next = dc_reg;
    cap_next = cap_reg;
    // Send second byte, or accept a new downlink message
    if (tx_pend_reg) begin
      tx_v_next = 1'b1;
      tx_l_next = 1'b1;
      tx_b_next = tx_hold_reg;
    end else if (send_req) begin
      b0[PCPC_POS_NEG] = (send_kind == PCPC_MSG_REJECT) ||
                         (send_kind == PCPC_MSG_DEM_BASE);
      b0[PCPC_POS_RQ +: PCPC_RQ_W] = send_rq;
      b0[PCPC_POS_TIME +: PCPC_TIME_W] = send_time;
      tx_v_next = 1'b1;
      tx_f_next = 1'b1;
      tx_b_next = b0;
      tx_pend_next = 1'b1;
      tx_hold_next = (send_kind == PCPC_MSG_REJECT) ? PCPC_NSID_NONE
                                                    : send_nsid;
      if (send_kind == PCPC_MSG_REQ_BASE) begin
        prom_next = 1'b1;
        sid_next = send_nsid;
      end else if (send_kind == PCPC_MSG_REJECT ||
                   send_kind == PCPC_MSG_DEM_BASE) begin
        prom_next = 1'b0;
      end
    end
    // Uplink collection and classification
    if (link.up_valid) begin
      rx_sh_next = full;
      rx_cnt_next = link.up_first ? 4'h1 : rx_cnt_reg + 4'h1;
      if (link.up_last && !link.up_first) begin
        rx_cnt_next = 4'h0;
        if (rx_cnt_reg == 4'(PCPC_SHORT_BYTES - 1)) begin
          k = pcpc_classify(1'b0, full[15], full[7:0]);
          if (k == PCPC_MSG_REQ_NODE) k = PCPC_MSG_INVALID;
        end else if (rx_cnt_reg == 4'(PCPC_LONG_BYTES - 1)) begin
          k = pcpc_classify(1'b0, full[BW-1], full[BW-9 -: 8]);
          if (k != PCPC_MSG_REQ_NODE) k = PCPC_MSG_INVALID;
        end
        if (k == PCPC_MSG_INVALID) begin
          disc_next = 1'b1;
        end else begin
          mv_next = 1'b1;
          mk_next = k;
          if (k == PCPC_MSG_REQ_NODE) begin
            na_next = full[BW-17 -: PCPC_ADDR_W];
            uc_next = full[23:16];
            dc_next = full[15:8];
            cap_next = full[3:0];
          end else if (k == PCPC_MSG_ACK) begin
            prom_next = 1'b1;
            sid_next = full[7:0];
          end else begin
            prom_next = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_b_reg <= 8'h00;
      tx_hold_reg <= 8'h00;
      tx_v_reg <= 1'b0;
      tx_f_reg <= 1'b0;
      tx_l_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      prom_reg <= 1'b0;
      sid_reg <= PCPC_NSID_NONE;
      rx_sh_reg <= '0;
      rx_cnt_reg <= 4'h0;
      mv_reg <= 1'b0;
      disc_reg <= 1'b0;
      mk_reg <= PCPC_MSG_INVALID;
      na_reg <= '0;
      uc_reg <= 8'h00;
      dc_reg <= 8'h00;
      cap_reg <= 4'h0;
    end else begin
      tx_b_reg <= tx_b_next;
      tx_hold_reg <= tx_hold_next;
      tx_v_reg <= tx_v_next;
      tx_f_reg <= tx_f_next;
      tx_l_reg <= tx_l_next;
      tx_pend_reg <= tx_pend_next;
      prom_reg <= prom_next;
      sid_reg <= sid_next;
      rx_sh_reg <= rx_sh_next;
      rx_cnt_reg <= rx_cnt_next;
      mv_reg <= mv_next;
      disc_reg <= disc_next;
      mk_reg <= mk_next;
      na_reg <= na_next;
      uc_reg <= uc_next;
      dc_reg <= dc_next;
      cap_reg <= cap_next;
    end
  end

  assign link.dn_valid = tx_v_reg;
  assign link.dn_first = tx_f_reg;
  assign link.dn_last  = tx_l_reg;
  assign link.dn_byte  = tx_b_reg;
  assign node_promoted = prom_reg;
  assign node_ident    = sid_reg;
  assign rx_msg_valid  = mv_reg;
  assign rx_msg_kind   = mk_reg;
  assign rx_need_addr  = na_reg;
  assign rx_up_cost    = uc_reg;
  assign rx_dn_cost    = dc_reg;
  assign rx_caps       = cap_reg;
  assign rx_discard    = disc_reg;
endmodule : pcpc_base_end

// file: pcpc_link_checker.sv
// Checker: framing and field coding on the promotion link
`timescale 1ns/1ps
module pcpc_link_checker (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       up_valid,
  input wire logic       up_first,
  input wire logic       up_last,
  input wire logic [7:0] up_byte,
  input wire logic       dn_valid,
  input wire logic       dn_first,
  input wire logic       dn_last,
  input wire logic [7:0] dn_byte
);
  // One clock domain, so one clocking and one disable for all
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_up_flag_valid: assert property (
    (up_first || up_last) |-> up_valid)
    else $error("uplink framing flag without a byte");
  chk_dn_flag_valid: assert property (
    (dn_first || dn_last) |-> dn_valid)
    else $error("downlink framing flag without a byte");
  chk_dn_short_form: assert property (
    dn_valid && dn_first |->
    !dn_byte[6] ##1 (dn_valid && dn_last && !dn_first))
    else $error("downlink packet not in short form");
  chk_up_neg_short: assert property (
    up_valid && up_first && up_byte[7] |->
    ##1 (up_valid && up_last && !up_first))
    else $error("negative uplink packet not short");
  // A positive uplink packet whose second byte is FF is the long request
  chk_up_long_form: assert property (
    up_valid && up_first && !up_byte[7]
    ##1 (up_valid && up_byte == 8'hFF) |-> !up_last
    ##1 (up_valid && !up_last) [*8]
    ##1 (up_valid && up_last && up_byte[7:4] == 4'h0))
    else $error("long request framing or reserved bits wrong");
  chk_up_short_pos: assert property (
    up_valid && up_first && !up_byte[7]
    ##1 (up_valid && up_byte != 8'hFF) |-> up_last)
    else $error("positive short uplink packet not two bytes");
  chk_up_resv_bit: assert property (
    up_valid && up_first |-> !up_byte[6])
    else $error("uplink reserved bit set");
  chk_up_gapless: assert property (
    up_valid && !up_last |=> up_valid)
    else $error("gap inside an uplink packet");
  chk_up_next_first: assert property (
    up_valid && up_last |=> !up_valid || up_first)
    else $error("uplink byte after last without first");
endmodule : pcpc_link_checker

// file: promotion_control_packet_codec_test.sv
// Testbench: node and base ends joined back to back over the link
`timescale 1ns/1ps
module promotion_control_packet_codec_test;
  import pcpc_pkg::*;
  typedef struct packed {
    logic        disc;
    pcpc_msg_t   kind;
    logic        prom;
    logic [7:0]  id;
    logic [67:0] fields;
  } pcpc_exp_t;

  logic      ref_clk = 0;
  logic      rst_n   = 0;
  logic      n_req   = 0;
  pcpc_msg_t n_kind  = PCPC_MSG_ACK;
  logic [2:0]  n_rq = 0, n_time = 0, b_rq = 0, b_time = 0;
  logic [7:0]  n_nsid = 0, n_up = 0, n_dn = 0, b_nsid = 0;
  logic [47:0] n_addr = 0;
  logic [3:0]  n_caps = 0, caps_sel = 0;
  logic      b_req   = 0;
  pcpc_msg_t b_kind  = PCPC_MSG_REQ_BASE;
  logic n_busy, n_prom, n_ka, n_val, n_disc, b_prom, b_val, b_disc;
  logic [7:0]  n_id, b_id, b_up, b_dn, id;
  logic [2:0]  n_code;
  logic [47:0] b_addr;
  logic [3:0]  b_caps;
  pcpc_msg_t n_rkind, b_rkind;
  pcpc_exp_t base_q[$], node_q[$];
  int errors = 0, check_count = 0, seed = 17, restarts = 0, exp_rst = 0;
  logic bprom = 0, nprom = 0;
  logic [7:0] bid = 8'hFF, nid = 8'hFF;

  always #12.5 ref_clk = ~ref_clk;

  pcpc_link_if link ();
  pcpc_node_end u_pcpc_node_end (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .send_req(n_req), .send_kind(n_kind), .send_rq(n_rq),
    .send_time(n_time), .send_nsid(n_nsid), .send_need_addr(n_addr),
    .send_up_cost(n_up), .send_dn_cost(n_dn), .cap_direct(n_caps[3]),
    .cap_multicast(n_caps[2]), .cap_robust(n_caps[1]),
    .cap_retransmit(n_caps[0]), .send_busy(n_busy), .promoted(n_prom),
    .switch_ident(n_id), .keepalive_restart(n_ka),
    .keepalive_code(n_code), .rx_msg_valid(n_val), .rx_msg_kind(n_rkind),
    .rx_discard(n_disc));
  pcpc_base_end u_pcpc_base_end (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .send_req(b_req), .send_kind(b_kind), .send_rq(b_rq),
    .send_time(b_time), .send_nsid(b_nsid), .node_promoted(b_prom),
    .node_ident(b_id), .rx_msg_valid(b_val), .rx_msg_kind(b_rkind),
    .rx_need_addr(b_addr), .rx_up_cost(b_up), .rx_dn_cost(b_dn),
    .rx_caps(b_caps), .rx_discard(b_disc));
  pcpc_link_checker u_pcpc_link_checker (.ref_clk(ref_clk), .rst_n(rst_n),
    .up_valid(link.up_valid), .up_first(link.up_first),
    .up_last(link.up_last), .up_byte(link.up_byte),
    .dn_valid(link.dn_valid), .dn_first(link.dn_first),
    .dn_last(link.dn_last), .dn_byte(link.dn_byte));

  task automatic check(string what, logic [80:0] exp, logic [80:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task automatic wrap_up();
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Node sends; base outcome is predicted from direction, flag and id
  task automatic node_send(pcpc_msg_t k, logic [7:0] nsid, logic [3:0] caps,
                           logic dup);
    logic [67:0] f;
    logic        d;
    f = 68'({$random(seed), $random(seed), $random(seed)});
    f[3:0] = caps;
    d = (nsid == 8'hFF) && (k != PCPC_MSG_REQ_NODE);
    // A demotion the node sends below FF demotes the node itself
    if (k == PCPC_MSG_DEM_NODE && nsid != 8'hFF) nprom = 0;
    if (!d && k == PCPC_MSG_ACK) begin
      bprom = 1;
      bid = nsid;
    end
    if (!d && k == PCPC_MSG_DEM_NODE) bprom = 0;
    base_q.push_back('{d, k, bprom, bid, f});
    {n_addr, n_up, n_dn} <= f[67:4];
    n_caps <= caps;
    n_kind <= k;
    n_nsid <= nsid;
    n_rq <= 3'($random(seed));
    n_time <= 3'($random(seed));
    n_req <= 1;
    @(posedge ref_clk);
    n_req <= dup; // Second request lands while busy and must vanish
    @(posedge ref_clk);
    n_req <= 0;
    for (int i = 0; i < 40 && n_busy !== 1'b0; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    if (k == PCPC_MSG_DEM_NODE) check("node self demote", nprom, n_prom);
  endtask : node_send

  // Base sends; gap 1 gives the closest spacing the base accepts
  task automatic base_send(pcpc_msg_t k, logic [7:0] nsid, int gap);
    logic [2:0] t;
    logic       d;
    t = 3'($random(seed));
    d = (k == PCPC_MSG_REQ_BASE) && (nsid == 8'hFF);
    bprom = (k == PCPC_MSG_REQ_BASE);
    bid = nsid;
    if (!d) begin
      nprom = (k == PCPC_MSG_REQ_BASE);
      nid = nsid;
      exp_rst += nprom;
    end
    node_q.push_back('{d, k, nprom, nid, {65'h0, t}});
    b_kind <= k;
    b_nsid <= nsid;
    b_time <= t;
    b_rq <= 3'($random(seed));
    b_req <= 1;
    @(posedge ref_clk);
    b_req <= 0;
    repeat (gap) @(posedge ref_clk);
  endtask : base_send

  // Base side results
  always @(posedge ref_clk) begin
    pcpc_exp_t e;
    if (rst_n && (b_val === 1'b1 || b_disc === 1'b1)) begin
      e = base_q.pop_front();
      check("base discard", e.disc, b_disc);
      if (!e.disc) check("base kind", e.kind, b_rkind);
      check("base promoted", e.prom, b_prom);
      if (e.prom) check("base ident", e.id, b_id);
      if (!e.disc && e.kind == PCPC_MSG_REQ_NODE)
        check("fields", e.fields, {b_addr, b_up, b_dn, b_caps});
    end
  end

  // Node side results
  always @(posedge ref_clk) begin
    pcpc_exp_t e;
    if (rst_n && n_ka === 1'b1) restarts++;
    if (rst_n && (n_val === 1'b1 || n_disc === 1'b1)) begin
      e = node_q.pop_front();
      check("node discard", e.disc, n_disc);
      if (!e.disc) check("node kind", e.kind, n_rkind);
      check("node promoted", e.prom, n_prom);
      if (e.prom) check("node ident", e.id, n_id);
      if (e.prom) check("keepalive code", e.fields[2:0], n_code);
    end
  end

  // Watchdog well past the roughly 150 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      caps_sel = (i < 4) ? 4'(1 << i) : 4'hF;
      node_send(PCPC_MSG_REQ_NODE, 8'hFF, caps_sel, i == 0);
    end
    id = 8'({$random(seed)} % 255);
    base_send(PCPC_MSG_REQ_BASE, id, 4);
    node_send(PCPC_MSG_ACK, id, 4'h0, 0);
    node_send(PCPC_MSG_DEM_NODE, id, 4'h0, 0);
    base_send(PCPC_MSG_REQ_BASE, 8'h00, 1);
    base_send(PCPC_MSG_REJECT, 8'hFF, 4);
    base_send(PCPC_MSG_REQ_BASE, 8'hFE, 4);
    base_send(PCPC_MSG_DEM_BASE, 8'hFE, 4);
    node_send(PCPC_MSG_DEM_NODE, 8'hFF, 4'h0, 0);
    base_send(PCPC_MSG_REQ_BASE, 8'hFF, 4);
    repeat (8) @(posedge ref_clk);
    check("base pending", 0, base_q.size());
    check("node pending", 0, node_q.size());
    check("restarts", exp_rst, restarts);
    wrap_up();
  end
endmodule : promotion_control_packet_codec_test
